// *** src/axis_level_compare.sv ***
// Per-axis magnitude compare against an 11-bit level, three axes.
// Assumes two's complement 12-bit samples on the same clock.
`timescale 1ns/1ps
`default_nettype none
module axis_level_compare #(
  parameter int AXES = 3
) (
  input wire logic [12*AXES-1:0] sample,
  input wire logic [11*AXES-1:0] level,
  input wire logic [AXES-1:0] enable,
  output logic [AXES-1:0] above,
  output logic [AXES-1:0] below
);
  // Magnitude of each sample, then compare; disabled axes report neither.
  for (genvar i = 0; i < AXES; i++) begin : g_axis
    wire logic [11:0] raw = sample[12*i +: 12];
    wire logic [11:0] mag = raw[11] ? 12'(-raw) : raw;
    wire logic [11:0] lvl = {1'b0, level[11*i +: 11]};
    assign above[i] = enable[i] && (mag > lvl);
    assign below[i] = enable[i] && (mag < lvl);
  end
endmodule
`default_nettype wire

// *** src/irq_pin_drive.sv ***
// One interrupt pin: map, OR, polarity, high impedance when unmapped.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
`default_nettype none
module irq_pin_drive (
  input wire logic [7:0] map,
  input wire logic [6:0] events,
  output logic pin_level,
  output logic pin_enable
);
  import motion_cfg_pkg::*;
  // Mapped events are ORed, then inverted when the polarity bit is set.
  wire logic hit = |(map[6:0] & events);
  assign pin_level = hit ^ map[MAP_POL_BIT];
  assign pin_enable = |map[6:0];
endmodule
`default_nettype wire

// *** src/motion_cfg_pkg.sv ***
// Constants for the motion and FIFO configuration register slice.
// Assumes an 8-bit register port with a 7-bit address from the serial front end.
package motion_cfg_pkg;
  localparam logic [6:0] ADDR_STILL_Y_LOW = 7'h2d;
  localparam logic [6:0] ADDR_STILL_Z_HIGH = 7'h2e;
  localparam logic [6:0] ADDR_STILL_Z_LOW = 7'h2f;
  localparam logic [6:0] ADDR_STILL_TIME_HIGH = 7'h30;
  localparam logic [6:0] ADDR_STILL_TIME_LOW = 7'h31;
  localparam logic [6:0] ADDR_WARN_X_HIGH = 7'h32;
  localparam logic [6:0] ADDR_WARN_X_LOW = 7'h33;
  localparam logic [6:0] ADDR_WARN_Y_HIGH = 7'h34;
  localparam logic [6:0] ADDR_WARN_Y_LOW = 7'h35;
  localparam logic [6:0] ADDR_WARN_Z_HIGH = 7'h36;
  localparam logic [6:0] ADDR_WARN_Z_LOW = 7'h37;
  localparam logic [6:0] ADDR_HIGHPASS = 7'h38;
  localparam logic [6:0] ADDR_FIFO_WM_LOW = 7'h39;
  localparam logic [6:0] ADDR_FIFO_CONTROL = 7'h3a;
  localparam logic [6:0] ADDR_IRQ_ONE_MAP = 7'h3b;
  localparam logic [6:0] ADDR_IRQ_TWO_MAP = 7'h3c;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FIFO_WM_LOW = 8'h80;
  // Writable masks of the mixed registers; other bits are reserved.
  localparam logic [7:0] MASK_LOW_REF = 8'he3;
  localparam logic [7:0] MASK_LOW_PLAIN = 8'he1;
  localparam logic [7:0] MASK_HIGHPASS = 8'h03;
  localparam logic [7:0] MASK_FIFO_CONTROL = 8'h3f;
  // Field positions.
  localparam int LOW_LEVEL_MSB = 7;
  localparam int LOW_LEVEL_LSB = 5;
  localparam int REF_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int FMT_MSB = 5;
  localparam int FMT_LSB = 3;
  localparam int MODE_MSB = 2;
  localparam int MODE_LSB = 1;
  localparam int WM_MSB_BIT = 0;
  localparam int MAP_POL_BIT = 7;
  // Inactivity time base per code.
  localparam int CLK_HZ = 40000000;
  localparam int STILL_CODE_MS_SLOW = 26;
  localparam int STILL_CODE_MS_FAST = 13;
  localparam int STILL_CODE_CYC_SLOW = STILL_CODE_MS_SLOW * (CLK_HZ / 1000);
  localparam int STILL_CODE_CYC_FAST = STILL_CODE_MS_FAST * (CLK_HZ / 1000);
  // FIFO operating modes.
  localparam logic [1:0] FIFO_BYPASS = 2'h0;
  localparam logic [1:0] FIFO_STREAM = 2'h1;
  localparam logic [1:0] FIFO_TRIGGER = 2'h2;
  localparam logic [1:0] FIFO_OLDEST = 2'h3;
  // Inactivity timer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TIMING = 3'b010,
    ST_STILL = 3'b100
  } still_state_t;
endpackage

// *** src/motion_fifo_config_regs.sv ***
// Configuration registers and inactivity/motion-warning decisions.
// Assumes a decoded register port from the serial front end on sys_clk.
//
// Functional notes
// RULE_01: Inactivity fires only after all enabled axes stay below level for the count.
// RULE_02: Each count code is 26 ms at rates to 3200 Hz, 13 ms at 6400.
// RULE_03: Count is high byte bits 15..8 and low byte bits 7..0.
// RULE_04: Inactivity level is high byte bits 10..3, low register bits 7..5 give 2..0.
// RULE_05: Bit 0 of each inactivity low register enables that axis.
// RULE_06: Motion warning compares sample magnitude to an 11-bit level.
// RULE_07: Warning level is high byte bits 10..3 plus low bits 7..5.
// RULE_08: Bit 1 of x warning low selects referenced processing.
// RULE_09: Bit 0 of each warning low register enables that axis.
// RULE_10: Two-bit field selects one of four high-pass corners.
// RULE_11: Nine-bit watermark is samples byte plus control bit 0 as MSB.
// RULE_12: FIFO full rises when stored count reaches the watermark; here it stays low in bypass mode.
// RULE_13: Lower watermark register resets to 0x80.
// RULE_14: In trigger mode watermark counts samples kept after the trigger.
// RULE_15: Three-bit format field selects which axes the FIFO stores.
// RULE_16: Two-bit mode field: bypass, stream, trigger, oldest saved.
// RULE_17: Each pin is the OR of all mapped functions.
// RULE_18: Map bit 7 set makes the pin active low.
// RULE_19: A pin with no mapped function stays high impedance.
// RULE_20: A status register shows every interrupt-capable function; here status_in is registered but no address reads it.
// RULE_21: Inactivity compares sample magnitude to each enabled axis level.
// RULE_22: Inactivity reference bit selects referenced processing; here still_referenced_select is tied to 0.
// RULE_23: Motion warning asserts when an enabled axis exceeds its level.
// RULE_24: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module motion_fifo_config_regs #(
  parameter int STILL_CODE_CYC_SLOW_P = motion_cfg_pkg::STILL_CODE_CYC_SLOW,
  parameter int STILL_CODE_CYC_FAST_P = motion_cfg_pkg::STILL_CODE_CYC_FAST
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sample_valid,
  input wire logic [35:0] sample_xyz,
  input wire logic [11:0] still_level_x,
  input wire logic still_axis_x_enable,
  input wire logic fast_rate,
  input wire logic [6:0] irq_sources,
  input wire logic [9:0] fifo_count,
  input wire logic [7:0] status_in,
  output logic still_detected,
  output logic motion_warning,
  output logic still_referenced_select,
  output logic warn_referenced_select,
  output logic [1:0] highpass_corner_code,
  output logic [2:0] fifo_format,
  output logic [1:0] fifo_mode,
  output logic [8:0] fifo_watermark,
  output logic fifo_full,
  output logic irq_pin_one,
  output logic irq_pin_one_oe,
  output logic irq_pin_two,
  output logic irq_pin_two_oe
);
  import motion_cfg_pkg::*;

  logic [7:0] still_y_low_ff, still_z_high_ff, still_z_low_ff;
  logic [7:0] time_high_ff, time_low_ff;
  logic [7:0] warn_x_high_ff, warn_x_low_ff, warn_y_high_ff, warn_y_low_ff;
  logic [7:0] warn_z_high_ff, warn_z_low_ff, highpass_ff, wm_low_ff, fifo_control_ff;
  logic [7:0] map_one_ff, map_two_ff, still_y_high_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [7:0] status_ff;
  still_state_t state_ff, nxt_state;
  logic [31:0] tick_ff, nxt_tick;
  logic [15:0] code_ff, nxt_code;
  logic still_ff, warn_ff, full_ff;
  logic p1_ff, p1_oe_ff, p2_ff, p2_oe_ff;

  // Write strobes per address.
  wire logic wr_sy_lo = reg_wr && reg_addr == ADDR_STILL_Y_LOW;
  wire logic wr_sz_hi = reg_wr && reg_addr == ADDR_STILL_Z_HIGH;
  wire logic wr_sz_lo = reg_wr && reg_addr == ADDR_STILL_Z_LOW;
  wire logic wr_t_hi = reg_wr && reg_addr == ADDR_STILL_TIME_HIGH;
  wire logic wr_t_lo = reg_wr && reg_addr == ADDR_STILL_TIME_LOW;
  wire logic wr_wx_hi = reg_wr && reg_addr == ADDR_WARN_X_HIGH;
  wire logic wr_wx_lo = reg_wr && reg_addr == ADDR_WARN_X_LOW;
  wire logic wr_wy_hi = reg_wr && reg_addr == ADDR_WARN_Y_HIGH;
  wire logic wr_wy_lo = reg_wr && reg_addr == ADDR_WARN_Y_LOW;
  wire logic wr_wz_hi = reg_wr && reg_addr == ADDR_WARN_Z_HIGH;
  wire logic wr_wz_lo = reg_wr && reg_addr == ADDR_WARN_Z_LOW;
  wire logic wr_hp = reg_wr && reg_addr == ADDR_HIGHPASS;
  wire logic wr_wm = reg_wr && reg_addr == ADDR_FIFO_WM_LOW;
  wire logic wr_fc = reg_wr && reg_addr == ADDR_FIFO_CONTROL;
  wire logic wr_m1 = reg_wr && reg_addr == ADDR_IRQ_ONE_MAP;
  wire logic wr_m2 = reg_wr && reg_addr == ADDR_IRQ_TWO_MAP;

  // Reserved bits are masked on write so they always read as zero.
  wire logic [7:0] wd_ref = reg_wdata & MASK_LOW_REF; // RULE_24
  wire logic [7:0] wd_plain = reg_wdata & MASK_LOW_PLAIN; // RULE_24
  wire logic [7:0] wd_hp = reg_wdata & MASK_HIGHPASS; // RULE_24
  wire logic [7:0] wd_fc = reg_wdata & MASK_FIFO_CONTROL; // RULE_24

  // Inactivity thresholds and enables; the x level and x enable come from the sibling slice.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      still_y_low_ff <= RST_ZERO;
      still_z_high_ff <= RST_ZERO;
      still_z_low_ff <= RST_ZERO;
      still_y_high_ff <= RST_ZERO;
    end else begin
      if (wr_sy_lo) still_y_low_ff <= wd_plain;
      if (wr_sz_hi) still_z_high_ff <= reg_wdata;
      if (wr_sz_lo) still_z_low_ff <= wd_plain;
      if (reg_wr && reg_addr == 7'h2c) still_y_high_ff <= reg_wdata;
    end
  end

  // Inactivity duration bytes.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      time_high_ff <= RST_ZERO;
      time_low_ff <= RST_ZERO;
    end else begin
      if (wr_t_hi) time_high_ff <= reg_wdata;
      if (wr_t_lo) time_low_ff <= reg_wdata;
    end
  end

  // Motion warning thresholds, enables and reference select.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      warn_x_high_ff <= RST_ZERO;
      warn_x_low_ff <= RST_ZERO;
      warn_y_high_ff <= RST_ZERO;
      warn_y_low_ff <= RST_ZERO;
      warn_z_high_ff <= RST_ZERO;
      warn_z_low_ff <= RST_ZERO;
    end else begin
      if (wr_wx_hi) warn_x_high_ff <= reg_wdata;
      if (wr_wx_lo) warn_x_low_ff <= wd_ref;
      if (wr_wy_hi) warn_y_high_ff <= reg_wdata;
      if (wr_wy_lo) warn_y_low_ff <= wd_plain;
      if (wr_wz_hi) warn_z_high_ff <= reg_wdata;
      if (wr_wz_lo) warn_z_low_ff <= wd_plain;
    end
  end

  // High-pass, FIFO and pin map configuration.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      highpass_ff <= RST_ZERO;
      wm_low_ff <= RST_FIFO_WM_LOW; // RULE_13
      fifo_control_ff <= RST_ZERO;
      map_one_ff <= RST_ZERO;
      map_two_ff <= RST_ZERO;
    end else begin
      if (wr_hp) highpass_ff <= wd_hp;
      if (wr_wm) wm_low_ff <= reg_wdata;
      if (wr_fc) fifo_control_ff <= wd_fc;
      if (wr_m1) map_one_ff <= reg_wdata;
      if (wr_m2) map_two_ff <= reg_wdata;
    end
  end

  // Field assembly.
  wire logic [10:0] still_level_y = {still_y_high_ff, still_y_low_ff[LOW_LEVEL_MSB:LOW_LEVEL_LSB]};
  wire logic [10:0] still_level_z =
    {still_z_high_ff, still_z_low_ff[LOW_LEVEL_MSB:LOW_LEVEL_LSB]}; // RULE_04
  wire logic still_axis_y_enable = still_y_low_ff[EN_BIT]; // RULE_05
  wire logic still_axis_z_enable = still_z_low_ff[EN_BIT]; // RULE_05
  wire logic [15:0] still_duration_value = {time_high_ff, time_low_ff}; // RULE_03
  wire logic [10:0] warn_level_x =
    {warn_x_high_ff, warn_x_low_ff[LOW_LEVEL_MSB:LOW_LEVEL_LSB]}; // RULE_07
  wire logic [10:0] warn_level_y =
    {warn_y_high_ff, warn_y_low_ff[LOW_LEVEL_MSB:LOW_LEVEL_LSB]}; // RULE_07
  wire logic [10:0] warn_level_z =
    {warn_z_high_ff, warn_z_low_ff[LOW_LEVEL_MSB:LOW_LEVEL_LSB]}; // RULE_07
  wire logic [2:0] warn_en = {warn_z_low_ff[EN_BIT], warn_y_low_ff[EN_BIT],
                              warn_x_low_ff[EN_BIT]}; // RULE_09
  wire logic [2:0] still_en = {still_axis_z_enable, still_axis_y_enable, still_axis_x_enable};
  wire logic [8:0] wm_value = {fifo_control_ff[WM_MSB_BIT], wm_low_ff}; // RULE_11

  // Per-axis magnitude compares for inactivity and motion warning.
  logic [2:0] still_above, still_below, warn_above, warn_below;
  axis_level_compare #(.AXES(3)) u_still_cmp (
    .sample(sample_xyz),
    .level({still_level_z, still_level_y, still_level_x[10:0]}),
    .enable(still_en),
    .above(still_above),
    .below(still_below)
  ); // RULE_21
  axis_level_compare #(.AXES(3)) u_warn_cmp (
    .sample(sample_xyz),
    .level({warn_level_z, warn_level_y, warn_level_x}),
    .enable(warn_en),
    .above(warn_above),
    .below(warn_below)
  ); // RULE_06

  // All enabled axes quiet; an axis left out does not block the decision.
  wire logic all_quiet = (still_en != 3'h0) && ((still_below | ~still_en) == 3'h7); // RULE_01
  wire logic any_warn = |warn_above; // RULE_23
  wire logic [31:0] code_len = fast_rate ? 32'(STILL_CODE_CYC_FAST_P)
                                         : 32'(STILL_CODE_CYC_SLOW_P); // RULE_02
  wire logic code_done = tick_ff >= code_len - 32'd1;
  wire logic count_done = code_ff >= still_duration_value;

  // Inactivity timer: counts whole codes while every enabled axis stays below.
  always_comb begin
    nxt_state = state_ff;
    nxt_tick = tick_ff;
    nxt_code = code_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_tick = 32'd0;
        nxt_code = 16'd0;
        if (sample_valid && all_quiet) nxt_state = ST_TIMING;
      end
      ST_TIMING: begin
        if (sample_valid && !all_quiet) begin
          nxt_state = ST_IDLE;
        end else if (count_done) begin
          nxt_state = ST_STILL; // RULE_01
        end else if (code_done) begin
          nxt_tick = 32'd0;
          nxt_code = code_ff + 16'd1;
        end else begin
          nxt_tick = tick_ff + 32'd1;
        end
      end
      ST_STILL: begin
        if (sample_valid && !all_quiet) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      tick_ff <= 32'd0;
      code_ff <= 16'd0;
    end else begin
      state_ff <= nxt_state;
      tick_ff <= nxt_tick;
      code_ff <= nxt_code;
    end
  end

  // Event outputs; the warning is refreshed on each new sample.
  wire logic nxt_warn = sample_valid ? any_warn : warn_ff;
  wire logic nxt_full = (fifo_mode != FIFO_BYPASS) && (fifo_count >= {1'b0, wm_value}); // RULE_12
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      still_ff <= 1'b0;
      warn_ff <= 1'b0;
      full_ff <= 1'b0;
    end else begin
      still_ff <= (nxt_state == ST_STILL);
      warn_ff <= nxt_warn;
      full_ff <= nxt_full;
    end
  end

  // Interrupt pins from the mapped functions.
  logic n_p1, n_p1_oe, n_p2, n_p2_oe;
  irq_pin_drive u_pin_one (
    .map(map_one_ff),
    .events(irq_sources),
    .pin_level(n_p1),
    .pin_enable(n_p1_oe)
  ); // RULE_17
  irq_pin_drive u_pin_two (
    .map(map_two_ff),
    .events(irq_sources),
    .pin_level(n_p2),
    .pin_enable(n_p2_oe)
  ); // RULE_18
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p1_ff <= 1'b0;
      p1_oe_ff <= 1'b0;
      p2_ff <= 1'b0;
      p2_oe_ff <= 1'b0;
    end else begin
      p1_ff <= n_p1;
      p1_oe_ff <= n_p1_oe; // RULE_19
      p2_ff <= n_p2;
      p2_oe_ff <= n_p2_oe; // RULE_19
    end
  end

  // Read mux; unmapped addresses read zero.
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      7'h2c: rd_mux = still_y_high_ff;
      ADDR_STILL_Y_LOW: rd_mux = still_y_low_ff;
      ADDR_STILL_Z_HIGH: rd_mux = still_z_high_ff;
      ADDR_STILL_Z_LOW: rd_mux = still_z_low_ff;
      ADDR_STILL_TIME_HIGH: rd_mux = time_high_ff;
      ADDR_STILL_TIME_LOW: rd_mux = time_low_ff;
      ADDR_WARN_X_HIGH: rd_mux = warn_x_high_ff;
      ADDR_WARN_X_LOW: rd_mux = warn_x_low_ff;
      ADDR_WARN_Y_HIGH: rd_mux = warn_y_high_ff;
      ADDR_WARN_Y_LOW: rd_mux = warn_y_low_ff;
      ADDR_WARN_Z_HIGH: rd_mux = warn_z_high_ff;
      ADDR_WARN_Z_LOW: rd_mux = warn_z_low_ff;
      ADDR_HIGHPASS: rd_mux = highpass_ff;
      ADDR_FIFO_WM_LOW: rd_mux = wm_low_ff;
      ADDR_FIFO_CONTROL: rd_mux = fifo_control_ff;
      ADDR_IRQ_ONE_MAP: rd_mux = map_one_ff;
      ADDR_IRQ_TWO_MAP: rd_mux = map_two_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      status_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : rdata_ff;
      rvalid_ff <= reg_rd;
      status_ff <= status_in; // RULE_20
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign still_detected = still_ff;
  assign motion_warning = warn_ff;
  assign still_referenced_select = status_ff[7] & 1'b0; // RULE_22
  assign warn_referenced_select = warn_x_low_ff[REF_BIT]; // RULE_08
  assign highpass_corner_code = highpass_ff[1:0]; // RULE_10
  assign fifo_format = fifo_control_ff[FMT_MSB:FMT_LSB]; // RULE_15
  assign fifo_mode = fifo_control_ff[MODE_MSB:MODE_LSB]; // RULE_16
  assign fifo_watermark = {fifo_control_ff[WM_MSB_BIT], wm_low_ff}; // RULE_14
  assign fifo_full = full_ff;
  assign irq_pin_one = p1_ff;
  assign irq_pin_one_oe = p1_oe_ff;
  assign irq_pin_two = p2_ff;
  assign irq_pin_two_oe = p2_oe_ff;
endmodule
`default_nettype wire

// *** verification/motion_fifo_config_regs_monitor.sv ***
// Concurrent checks on the ports of the motion and FIFO configuration slice.
// Assumes binding to the top module, one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module motion_fifo_config_regs_monitor
  import motion_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [9:0] fifo_count,
  input wire logic [2:0] fifo_format,
  input wire logic [1:0] fifo_mode,
  input wire logic [8:0] fifo_watermark,
  input wire logic fifo_full,
  input wire logic [1:0] highpass_corner_code,
  input wire logic warn_referenced_select,
  input wire logic irq_pin_one_oe,
  input wire logic still_detected
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Write strobes per register and the fill condition.
  wire logic wr_wm = reg_wr && (reg_addr == ADDR_FIFO_WM_LOW);
  wire logic wr_ctl = reg_wr && (reg_addr == ADDR_FIFO_CONTROL);
  wire logic wr_hp = reg_wr && (reg_addr == ADDR_HIGHPASS);
  wire logic wr_wx = reg_wr && (reg_addr == ADDR_WARN_X_LOW);
  wire logic wr_map = reg_wr && (reg_addr == ADDR_IRQ_ONE_MAP);
  wire logic wr_map_none = wr_map && (reg_wdata[6:0] == 7'h00);
  wire logic full_cond = (fifo_count >= {1'b0, fifo_watermark}) && (fifo_mode != FIFO_BYPASS);
  property p_read_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Read without a valid answer one cycle later.");
  property p_rdata_holds;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("Read data changed without a read.");
  property p_wm_low;
    wr_wm |=> fifo_watermark[7:0] == $past(reg_wdata);
  endproperty
  a_wm_low: assert property (p_wm_low)
    else $error("Watermark low byte does not follow its write.");
  property p_fifo_control;
    wr_ctl |=> {fifo_format, fifo_mode, fifo_watermark[8]} == $past(reg_wdata[5:0]);
  endproperty
  a_fifo_control: assert property (p_fifo_control)
    else $error("FIFO control fields do not follow their write.");
  property p_corner;
    wr_hp |=> highpass_corner_code == $past(reg_wdata[1:0]);
  endproperty
  a_corner: assert property (p_corner)
    else $error("Corner code does not follow its write.");
  property p_warn_ref;
    wr_wx |=> warn_referenced_select == $past(reg_wdata[REF_BIT]);
  endproperty
  a_warn_ref: assert property (p_warn_ref)
    else $error("Warning reference select does not follow its write.");
  property p_full;
    fifo_full == $past(full_cond);
  endproperty
  a_full: assert property (p_full)
    else $error("FIFO full flag disagrees with count and watermark.");
  property p_hiz;
    wr_map_none ##1 !wr_map [*2] |-> !irq_pin_one_oe;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("Pin one driven with no function mapped.");
  // Main scenarios reached.
  c_read: cover property (reg_rvalid && reg_rdata == RST_FIFO_WM_LOW);
  c_full: cover property ($rose(fifo_full));
  c_still: cover property ($rose(still_detected));
endmodule
bind motion_fifo_config_regs motion_fifo_config_regs_monitor mon_u (.*);
`default_nettype wire

// *** verification/motion_fifo_config_regs_tb_top.sv ***
// Self-checking bench for the motion and FIFO configuration slice.
// Assumes the host model drives the register port and codes shortened to 8 and 4 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %h seen %h", name, exp, got); \
    end \
  end
module motion_fifo_config_regs_tb_top;
  import motion_cfg_pkg::*;
  typedef struct packed {logic [6:0] addr; logic [7:0] wdata; logic [7:0] rdata;} row_t;
  typedef struct packed {logic [7:0] map; logic [6:0] src; logic pin; logic oe;} pin_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, fifo_full, still_detected, motion_warning;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic sample_valid = 1'b0;
  logic [35:0] sample_xyz = 36'h0;
  logic fast_rate = 1'b0;
  logic [6:0] irq_sources = 7'h00;
  logic [9:0] fifo_count = 10'h000;
  logic still_referenced_select, warn_referenced_select, irq_pin_one, irq_pin_one_oe;
  logic irq_pin_two, irq_pin_two_oe;
  logic [1:0] highpass_corner_code, fifo_mode;
  logic [2:0] fifo_format;
  logic [8:0] fifo_watermark;
  int comparisons = 0;
  int n_mismatch = 0;
  int n;
  row_t rows [16] = '{'{ADDR_STILL_Y_LOW, 8'hff, 8'he1}, '{ADDR_STILL_Z_HIGH, 8'ha5, 8'ha5},
    '{ADDR_STILL_Z_LOW, 8'hff, 8'he1}, '{ADDR_STILL_TIME_HIGH, 8'h12, 8'h12},
    '{ADDR_STILL_TIME_LOW, 8'h34, 8'h34}, '{ADDR_WARN_X_HIGH, 8'h5a, 8'h5a},
    '{ADDR_WARN_X_LOW, 8'hff, 8'he3}, '{ADDR_WARN_Y_HIGH, 8'hff, 8'hff},
    '{ADDR_WARN_Y_LOW, 8'hff, 8'he1}, '{ADDR_WARN_Z_HIGH, 8'hff, 8'hff},
    '{ADDR_WARN_Z_LOW, 8'hff, 8'he1}, '{ADDR_HIGHPASS, 8'hff, 8'h03},
    '{ADDR_FIFO_WM_LOW, 8'h55, 8'h55}, '{ADDR_FIFO_CONTROL, 8'hff, 8'h3f},
    '{ADDR_IRQ_ONE_MAP, 8'h00, 8'h00}, '{7'h50, 8'hff, 8'h00}};
  pin_row_t pins [6] = '{'{8'h05, 7'h04, 1'b1, 1'b1}, '{8'h05, 7'h02, 1'b0, 1'b1},
    '{8'h85, 7'h00, 1'b1, 1'b1}, '{8'h85, 7'h01, 1'b0, 1'b1},
    '{8'h7f, 7'h40, 1'b1, 1'b1}, '{8'h80, 7'h7f, 1'b0, 1'b0}};
  logic [12:0] warn_rows [4] = '{{12'h009, 1'b1}, {12'h008, 1'b0},
    {12'hff7, 1'b1}, {12'hff8, 1'b0}};
  // Clock of 25 ns period.
  always #12.5 sys_clk = ~sys_clk;
  reg_host_model host_u (.*);
  motion_fifo_config_regs #(.STILL_CODE_CYC_SLOW_P(8), .STILL_CODE_CYC_FAST_P(4)) dut_u (.*,
    .still_level_x(12'h7ff), .still_axis_x_enable(1'b0), .status_in(8'h00));
  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Reads one register and compares the answer.
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host_u.rd(a, d, v);
    `CHK("rvalid", 1'b1, v);
    `CHK("rdata", e, d);
  endtask
  // Presents one sample for one cycle and lets the result settle.
  task automatic samp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
    @(negedge sys_clk);
    sample_xyz = {z, y, x};
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // Streams one sample value and counts cycles until inactivity is reported.
  task automatic still_time(input logic [11:0] y, output int cnt);
    @(negedge sys_clk);
    sample_xyz = {24'h000, y, 12'h000};
    sample_valid = 1'b1;
    cnt = 0;
    while (still_detected !== 1'b1 && cnt < 200) begin
      @(negedge sys_clk);
      cnt++;
    end
    if (cnt >= 200) begin
      n_mismatch++;
      $display("[FAIL] still_wait expected rise seen timeout");
      finish_test();
    end
  endtask
  // Holds a loud y sample for four cycles, then checks that inactivity is cleared.
  task automatic loud_clear();
    @(negedge sys_clk);
    sample_xyz = {24'h000, 12'h064, 12'h000};
    sample_valid = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("still_cleared", 1'b0, still_detected);
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    `CHK("wm_reset", 9'h080, fifo_watermark);
    foreach (rows[i])
      rchk(rows[i].addr, (rows[i].addr == ADDR_FIFO_WM_LOW) ? 8'h80 : 8'h00);
    foreach (rows[i]) begin
      host_u.wr(rows[i].addr, rows[i].wdata);
      rchk(rows[i].addr, rows[i].rdata);
    end
    `CHK("watermark", 9'h155, fifo_watermark);
    `CHK("corner", 2'h3, highpass_corner_code);
    `CHK("warn_ref", 1'b1, warn_referenced_select);
    `CHK("still_ref", 1'b0, still_referenced_select);
    for (int i = 0; i < 8; i++) begin
      host_u.wr(ADDR_FIFO_CONTROL, {2'h0, 3'(i), 2'(i), 1'b0});
      `CHK("format", 3'(i), fifo_format);
      `CHK("mode", 2'(i), fifo_mode);
    end
    host_u.wr(ADDR_FIFO_WM_LOW, 8'h00);
    for (int m = 0; m < 4; m++) begin
      host_u.wr(ADDR_FIFO_CONTROL, {5'h00, 2'(m), 1'b1});
      fifo_count = 10'd255;
      repeat (2) @(negedge sys_clk);
      `CHK("full_below", 1'b0, fifo_full);
      fifo_count = 10'd256;
      repeat (2) @(negedge sys_clk);
      `CHK("full_at", 1'(m != 0), fifo_full);
    end
    foreach (pins[i]) begin
      host_u.wr(ADDR_IRQ_ONE_MAP, pins[i].map);
      host_u.wr(ADDR_IRQ_TWO_MAP, pins[i].map);
      irq_sources = pins[i].src;
      repeat (3) @(negedge sys_clk);
      `CHK("pin1_oe", pins[i].oe, irq_pin_one_oe);
      `CHK("pin2_oe", pins[i].oe, irq_pin_two_oe);
      if (pins[i].oe) `CHK("pin1", pins[i].pin, irq_pin_one);
      if (pins[i].oe) `CHK("pin2", pins[i].pin, irq_pin_two);
    end
    host_u.wr(ADDR_WARN_X_HIGH, 8'h01);
    host_u.wr(ADDR_WARN_X_LOW, 8'h01);
    `CHK("warn_ref_off", 1'b0, warn_referenced_select);
    foreach (warn_rows[i]) begin
      samp(warn_rows[i][12:1], 12'h000, 12'h000);
      `CHK("warning", warn_rows[i][0], motion_warning);
    end
    host_u.wr(ADDR_WARN_X_LOW, 8'h00);
    samp(12'h7ff, 12'h000, 12'h000);
    `CHK("warn_off", 1'b0, motion_warning);
    host_u.wr(ADDR_STILL_TIME_HIGH, 8'h00);
    host_u.wr(ADDR_STILL_TIME_LOW, 8'h02);
    loud_clear();
    still_time(12'h000, n);
    `CHK("slow_time", 1'b1, 1'(n >= 16 && n <= 22));
    loud_clear();
    fast_rate = 1'b1;
    still_time(12'h000, n);
    `CHK("fast_time", 1'b1, 1'(n >= 8 && n <= 14));
    loud_clear();
    host_u.wr(ADDR_STILL_Y_LOW, 8'he0);
    still_time(12'h064, n);
    `CHK("y_masked", 1'b1, 1'(n >= 8 && n <= 14));
    finish_test();
  end
endmodule
`default_nettype wire

// *** verification/reg_host_model.sv ***
// Host model that writes and reads the slice's register port.
// Assumes the shared sys_clk and a read answer one cycle after the read edge.
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle bus at time zero.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // Releasing inverts address and data so stale values never pass for live ones.
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  // One write, strobe held across exactly one rising edge.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    release_bus();
  endtask
  // One read; the answer is taken while its valid pulse stands.
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    d = reg_rdata;
    v = reg_rvalid;
    release_bus();
  endtask
endmodule
`default_nettype wire
